/* dv/scx_apb_host.sv */
// apb host model issuing register transfers
`timescale 1ns/10ps
module scx_apb_host (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // one transfer, held until pready seen at a rising edge
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the sensor control slice
`timescale 1ns/10ps
`include "scx_regs.svh"
module testbench;
  logic        clk, srst, powerDown, psel, penable, pwrite, pready, pslverr, err;
  logic        vsyncOut, pixClkOut, lineValidOut, compositeHsyncOut, syncOe, dataOe;
  logic        exposeActive, prev;
  logic [9:0]  pixData;
  logic [11:0] paddr;
  logic [13:0] snap;
  logic [31:0] pwdata, prdata, rd, lfsrQ;
  int          errors, tests_run, cycles, n0, n1, n2;
  logic [9:0]  idxT [4] = '{`SCX_IDX_PD_PIN, `SCX_IDX_MODE_RST, `SCX_IDX_EXP_MID,
                            `SCX_IDX_CLK_RATE};
  logic [15:0] divT [6] = '{16'h0001, 16'h3f01, 16'h4002, 16'h4104, 16'h450c, 16'h7f80};
  logic [31:0] expT [6] = '{32'h00000000, 32'h0000ff07, 32'h00040525, 32'h40000000,
                            32'h00050128, 32'h01000028};
  ////////////////////////////////////////////////////////////
  scx_top DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .powerDown, .vsyncOut, .pixClkOut, .lineValidOut, .compositeHsyncOut,
    .syncOe, .pixData, .dataOe, .exposeActive);
  scx_apb_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    host.xfer(1'b1, idx, {24'h000000, v}, rd, err);
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 32'h00000000, rd, err);
    chk(rd, exp);
  endtask
  // cycles from a mode write to the following vsync fall
  task automatic mode_gap(input int d, input logic [3:0] code, output int n);
    @(posedge clk iff vsyncOut === 1'b1);
    @(posedge clk iff vsyncOut === 1'b0);
    repeat (d) @(posedge clk);
    wr(`SCX_IDX_RES_SEL, {1'b0, code, 3'b000});
    n = 0;
    while (vsyncOut !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    while (vsyncOut !== 1'b0) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    srst = 1'b1;
    powerDown = 1'b0;
    lfsrQ = 32'h59a0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rdchk(`SCX_IDX_PD_PIN, 32'h06);
    rdchk(`SCX_IDX_RSVD, 32'h01);
    rdchk(`SCX_IDX_MODE_RST, 32'h43);
    rdchk(`SCX_IDX_EXP_MID, 32'h63);
    rdchk(`SCX_IDX_CLK_RATE, 32'h00);
    for (int i = 0; i < 12; i++) begin
      lfsrQ = lfsr_next(lfsrQ);
      wr(idxT[i % 4], lfsrQ[7:0]);
      rdchk(idxT[i % 4], {24'h000000, lfsrQ[7:0]});
    end
    wr(`SCX_IDX_RSVD, 8'hff);
    rdchk(`SCX_IDX_RSVD, 32'h01);
    host.xfer(1'b0, 10'h3f0, 32'h00000000, rd, err);
    chk({err, rd[30:0]}, 32'h80000000);
    // divider: toggle spacing of the pixel clock
    for (int i = 0; i < 6; i++) begin
      wr(`SCX_IDX_CLK_RATE, divT[i][15:8]);
      repeat (300) @(posedge clk);
      prev = pixClkOut;
      while (pixClkOut === prev) @(posedge clk);
      prev = pixClkOut;
      n1 = 0;
      while (pixClkOut === prev) begin
        @(posedge clk);
        n1++;
      end
      chk(n1, divT[i][7:0]);
    end
    wr(`SCX_IDX_CLK_RATE, 8'h00);
    // power-down pin behaviour for each hold setting
    for (int m = 0; m < 4; m++) begin
      wr(`SCX_IDX_PD_PIN, 8'(m << 1));
      repeat (4) @(posedge clk);
      chk({syncOe, dataOe}, 32'h3);
      powerDown <= 1'b1;
      repeat (4) @(posedge clk);
      snap = {vsyncOut, pixClkOut, lineValidOut, compositeHsyncOut, pixData};
      chk(syncOe, m[0]);
      chk(dataOe, m[1]);
      repeat (50) @(posedge clk);
      if (m[0]) chk({vsyncOut, pixClkOut, lineValidOut, compositeHsyncOut}, snap[13:10]);
      if (m[1]) chk(pixData, snap[9:0]);
      powerDown <= 1'b0;
    end
    // exposure lines counted over one whole frame
    for (int i = 0; i < 6; i++) begin
      wr(`SCX_IDX_EXP_HIGH, expT[i][31:24]);
      wr(`SCX_IDX_EXP_MID, expT[i][23:16]);
      wr(`SCX_IDX_EXP_LOW, expT[i][15:8]);
      repeat (5200) @(posedge clk);
      n1 = 0;
      repeat (2560) begin
        @(posedge clk);
        if (exposeActive === 1'b1) n1++;
      end
      chk(n1, expT[i][7:0] * 64);
    end
    rdchk(`SCX_IDX_STATUS, 32'h02);
    // mode change with and without timing restart
    wr(`SCX_IDX_MODE_RST, 8'h43);
    mode_gap(300, 4'h1, n0);
    mode_gap(900, 4'h2, n2);
    chk(n2, n0);
    chk(n0 < 200, 1'b1);
    wr(`SCX_IDX_MODE_RST, 8'h41);
    mode_gap(300, 4'h4, n1);
    mode_gap(900, 4'h8, n2);
    chk(n1 - n2, 600);
    wr(`SCX_IDX_MODE_RST, 8'h43);
    mode_gap(1500, 4'h0, n2);
    chk(n2, n0);
    report_and_stop();
  end
endmodule

/* hw/scx_clk_div.sv */
// system clock divider producing a one-cycle tick
`timescale 1ns/10ps
`include "scx_regs.svh"
module scx_clk_div (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // divider control
  scx_clk_if.div    ctl
);
  logic [8:0] cntQ;
  logic [8:0] cntD;
  logic       tickQ;
  logic       tickD;
  logic [8:0] limit;

  always_comb begin
    if (ctl.divField == 6'h00) begin
      limit = 9'h001; // R8
    end else begin
      limit = 9'(({3'h0, ctl.divField} + 9'h001) * `SCX_DIV_MULT) - 9'h001; // R9
    end
    if (!ctl.divOn) begin
      cntD  = 9'h000; // R7
      tickD = 1'b1; // R7
    end else if (cntQ >= limit) begin
      cntD  = 9'h000;
      tickD = 1'b1;
    end else begin
      cntD  = cntQ + 9'h001;
      tickD = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cntQ  <= 9'h000;
      tickQ <= 1'b0;
    end else begin
      cntQ  <= cntD;
      tickQ <= tickD;
    end
  end

  assign ctl.tick = tickQ;

  bypass_tick_a: assert property (@(posedge clk) disable iff (srst)
    !ctl.divOn |=> tickQ) else $error("bypass tick missing"); // R7
  half_rate_a: assert property (@(posedge clk) disable iff (srst)
    ctl.divOn && ctl.divField == 6'h00 && $past(ctl.divOn) && $past(ctl.divField) == 6'h00
    && !$past(srst) |-> tickQ != $past(tickQ)) else $error("divide by two broken"); // R8
endmodule

/* hw/scx_top.sv */
// sensor control register slice with timing, exposure and pin control
// Summary of operation
// R1 - data pins tri-state at power-down when bit 2 is 0, else hold
// R2 - sync and pixel clock pins tri-state at power-down when bit 1 is 0, else hold
// R3 - bit 1 set: sensor timing restarts when working mode changes
// R4 - exposure count is high bits, middle register and low bits joined
// R5 - exposure lasts the count times one line period
// R6 - applied exposure never exceeds one frame
// R7 - bit 6 clear takes system clock straight, set uses divider
// R8 - divider field zero divides by two
// R9 - nonzero field divides by field plus one times a multiplier
// R10 - resolution field bits 6:3 selects working mode
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "scx_regs.svh"
module scx_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // sensor control
  input  wire logic        powerDown,
  // sync pins
  output logic             vsyncOut,
  output logic             pixClkOut,
  output logic             lineValidOut,
  output logic             compositeHsyncOut,
  output logic             syncOe,
  // data pins
  output logic [9:0]       pixData,
  output logic             dataOe,
  // exposure state
  output logic             exposeActive
);

  ////////////////////////////////////////////////////////////////
  // decode
  function automatic logic regHit(input logic [11:0] a, input logic [9:0] idx);
    regHit = (a == {idx, 2'b00});
  endfunction

  scx_clk_if clkIf ();

  scx_clk_div uDiv (
    .clk  (clk),
    .srst (srst),
    .ctl  (clkIf.div)
  );

  ////////////////////////////////////////////////////////////////
  // apb and registers
  scx_pkg::scx_apb_e apbQ;
  scx_pkg::scx_apb_e apbD;
  logic [7:0]        pdPinQ;
  logic [7:0]        pdPinD;
  logic [7:0]        modeRstQ;
  logic [7:0]        modeRstD;
  logic [7:0]        expMidQ;
  logic [7:0]        expMidD;
  logic [7:0]        clkRateQ;
  logic [7:0]        clkRateD;
  logic [7:0]        resSelQ;
  logic [7:0]        resSelD;
  logic [7:0]        expHighQ;
  logic [7:0]        expHighD;
  logic [7:0]        expLowQ;
  logic [7:0]        expLowD;
  logic [31:0]       rdataQ;
  logic [31:0]       rdataD;
  logic              errQ;
  logic              errD;
  logic              readyQ;
  logic              readyD;
  logic              modeChgQ;
  logic              modeChgD;
  logic              wrEn;
  logic              mapped;
  logic [7:0]        rdByte;
  logic [7:0]        statusByte;

  always_comb begin
    wrEn   = psel && penable && pwrite && (apbQ == scx_pkg::SCX_APB_DONE);
    mapped = regHit(paddr, `SCX_IDX_PD_PIN) || regHit(paddr, `SCX_IDX_RSVD)
          || regHit(paddr, `SCX_IDX_MODE_RST) || regHit(paddr, `SCX_IDX_EXP_MID)
          || regHit(paddr, `SCX_IDX_CLK_RATE) || regHit(paddr, `SCX_IDX_RES_SEL)
          || regHit(paddr, `SCX_IDX_EXP_HIGH) || regHit(paddr, `SCX_IDX_EXP_LOW)
          || regHit(paddr, `SCX_IDX_STATUS);
    rdByte = 8'h00;
    if (regHit(paddr, `SCX_IDX_PD_PIN)) rdByte = pdPinQ;
    if (regHit(paddr, `SCX_IDX_RSVD)) rdByte = `SCX_RST_RSVD;
    if (regHit(paddr, `SCX_IDX_MODE_RST)) rdByte = modeRstQ;
    if (regHit(paddr, `SCX_IDX_EXP_MID)) rdByte = expMidQ;
    if (regHit(paddr, `SCX_IDX_CLK_RATE)) rdByte = clkRateQ;
    if (regHit(paddr, `SCX_IDX_RES_SEL)) rdByte = resSelQ;
    if (regHit(paddr, `SCX_IDX_EXP_HIGH)) rdByte = expHighQ;
    if (regHit(paddr, `SCX_IDX_EXP_LOW)) rdByte = expLowQ;
    if (regHit(paddr, `SCX_IDX_STATUS)) rdByte = statusByte;
    apbD   = apbQ;
    rdataD = rdataQ;
    errD   = 1'b0;
    case (apbQ)
      scx_pkg::SCX_APB_IDLE: begin
        if (psel && !penable) begin
          apbD = scx_pkg::SCX_APB_WAIT;
        end
      end
      scx_pkg::SCX_APB_WAIT: begin
        apbD   = scx_pkg::SCX_APB_DONE;
        rdataD = pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
        errD   = !mapped;
      end
      scx_pkg::SCX_APB_DONE: begin
        apbD   = scx_pkg::SCX_APB_IDLE;
        rdataD = 32'h0000_0000;
      end
      default: begin
        apbD = scx_pkg::SCX_APB_IDLE;
      end
    endcase
    readyD   = (apbD == scx_pkg::SCX_APB_DONE);
    pdPinD   = (wrEn && regHit(paddr, `SCX_IDX_PD_PIN)) ? pwdata[7:0] : pdPinQ;
    modeRstD = (wrEn && regHit(paddr, `SCX_IDX_MODE_RST)) ? pwdata[7:0] : modeRstQ;
    expMidD  = (wrEn && regHit(paddr, `SCX_IDX_EXP_MID)) ? pwdata[7:0] : expMidQ;
    clkRateD = (wrEn && regHit(paddr, `SCX_IDX_CLK_RATE)) ? pwdata[7:0] : clkRateQ;
    resSelD  = (wrEn && regHit(paddr, `SCX_IDX_RES_SEL)) ? pwdata[7:0] : resSelQ; // R10
    expHighD = (wrEn && regHit(paddr, `SCX_IDX_EXP_HIGH)) ? pwdata[7:0] : expHighQ;
    expLowD  = (wrEn && regHit(paddr, `SCX_IDX_EXP_LOW)) ? pwdata[7:0] : expLowQ;
    modeChgD = (resSelD[`SCX_RES_HI:`SCX_RES_LO] != resSelQ[`SCX_RES_HI:`SCX_RES_LO]); // R10
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      apbQ     <= scx_pkg::SCX_APB_IDLE;
      pdPinQ   <= `SCX_RST_PD_PIN;
      modeRstQ <= `SCX_RST_MODE_RST;
      expMidQ  <= `SCX_RST_EXP_MID;
      clkRateQ <= `SCX_RST_CLK_RATE;
      resSelQ  <= `SCX_RST_RES_SEL;
      expHighQ <= `SCX_RST_EXP_HIGH;
      expLowQ  <= `SCX_RST_EXP_LOW;
      rdataQ   <= 32'h0000_0000;
      errQ     <= 1'b0;
      readyQ   <= 1'b0;
      modeChgQ <= 1'b0;
    end else begin
      apbQ     <= apbD;
      pdPinQ   <= pdPinD;
      modeRstQ <= modeRstD;
      expMidQ  <= expMidD;
      clkRateQ <= clkRateD;
      resSelQ  <= resSelD;
      expHighQ <= expHighD;
      expLowQ  <= expLowD;
      rdataQ   <= rdataD;
      errQ     <= errD;
      readyQ   <= readyD;
      modeChgQ <= modeChgD;
    end
  end

  assign pready  = readyQ;
  assign prdata  = rdataQ;
  assign pslverr = errQ;

  assign clkIf.divOn    = clkRateQ[`SCX_BIT_DIV_ON]; // R7
  assign clkIf.divField = clkRateQ[5:0]; // R8 R9

  ////////////////////////////////////////////////////////////////
  // exposure
  scx_pkg::scx_exp_t expCount;
  scx_pkg::scx_exp_t expApplied;

  always_comb begin
    expCount   = {expHighQ[5:0], expMidQ, expLowQ[2:0]}; // R4
    expApplied = (expCount > `SCX_FRAME_LINES) ? `SCX_FRAME_LINES : expCount; // R6
  end

  ////////////////////////////////////////////////////////////////
  // sensor timing and pins
  logic [11:0] pixQ;
  logic [11:0] pixD;
  logic [16:0] lineQ;
  logic [16:0] lineD;
  logic        pclkQ;
  logic        pclkD;
  logic        vsQ;
  logic        vsD;
  logic        lvQ;
  logic        lvD;
  logic        hsQ;
  logic        hsD;
  logic        syncOeQ;
  logic        syncOeD;
  logic [9:0]  dataQ;
  logic [9:0]  dataD;
  logic        dataOeQ;
  logic        dataOeD;
  logic        expQ;
  logic        expD;
  logic        run;
  logic        timRst;

  always_comb begin
    run    = clkIf.tick && !powerDown;
    timRst = modeChgQ && modeRstQ[`SCX_BIT_MODE_RST]; // R3
    pixD   = pixQ;
    lineD  = lineQ;
    if (timRst) begin
      pixD  = 12'h000; // R3
      lineD = 17'h00000; // R3
    end else if (run) begin
      if (pixQ == `SCX_LINE_TICKS - 12'h001) begin
        pixD  = 12'h000;
        lineD = (lineQ == `SCX_FRAME_LINES - 17'h00001) ? 17'h00000 : lineQ + 17'h00001;
      end else begin
        pixD = pixQ + 12'h001;
      end
    end
    pclkD = pclkQ;
    vsD   = vsQ;
    lvD   = lvQ;
    hsD   = hsQ;
    dataD = dataQ;
    expD  = expQ;
    if (run) begin
      pclkD = !pclkQ;
      vsD   = lineQ < `SCX_VSYNC_LINES;
      lvD   = (pixQ < `SCX_ACTIVE_PIX) && (lineQ < `SCX_ACTIVE_LINES);
      hsD   = pixQ >= `SCX_ACTIVE_PIX;
      dataD = lvD ? pixQ[9:0] : 10'h000;
      expD  = (expApplied != 17'h00000)
           && (lineQ >= `SCX_FRAME_LINES - expApplied); // R5
    end
    syncOeD = !powerDown || pdPinQ[`SCX_BIT_SYNC_HOLD]; // R2
    dataOeD = !powerDown || pdPinQ[`SCX_BIT_DATA_HOLD]; // R1
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pixQ    <= 12'h000;
      lineQ   <= 17'h00000;
      pclkQ   <= 1'b0;
      vsQ     <= 1'b0;
      lvQ     <= 1'b0;
      hsQ     <= 1'b0;
      syncOeQ <= 1'b0;
      dataQ   <= 10'h000;
      dataOeQ <= 1'b0;
      expQ    <= 1'b0;
    end else begin
      pixQ    <= pixD;
      lineQ   <= lineD;
      pclkQ   <= pclkD;
      vsQ     <= vsD;
      lvQ     <= lvD;
      hsQ     <= hsD;
      syncOeQ <= syncOeD;
      dataQ   <= dataD;
      dataOeQ <= dataOeD;
      expQ    <= expD;
    end
  end

  assign vsyncOut          = vsQ;
  assign pixClkOut         = pclkQ;
  assign lineValidOut      = lvQ;
  assign compositeHsyncOut = hsQ;
  assign syncOe            = syncOeQ;
  assign pixData           = dataQ;
  assign dataOe            = dataOeQ;
  assign exposeActive      = expQ;
  assign statusByte        = {6'h00, expQ, powerDown};

  ////////////////////////////////////////////////////////////////
  // checks
  apb_wait_a: assert property (@(posedge clk) disable iff (srst)
    psel && !penable && apbQ == scx_pkg::SCX_APB_IDLE |=> !pready ##1 pready)
    else $error("apb answer timing wrong");
  data_tri_a: assert property (@(posedge clk) disable iff (srst)
    powerDown && !pdPinQ[`SCX_BIT_DATA_HOLD] |=> !dataOe) else $error("data not tri-stated"); // R1
  data_hold_a: assert property (@(posedge clk) disable iff (srst)
    powerDown && pdPinQ[`SCX_BIT_DATA_HOLD] && !timRst |=> dataOe && $stable(pixData))
    else $error("data not held"); // R1
  sync_tri_a: assert property (@(posedge clk) disable iff (srst)
    powerDown && !pdPinQ[`SCX_BIT_SYNC_HOLD] |=> !syncOe) else $error("sync not tri-stated"); // R2
  sync_hold_a: assert property (@(posedge clk) disable iff (srst)
    powerDown && pdPinQ[`SCX_BIT_SYNC_HOLD] |=> syncOe && $stable(vsyncOut)
    && $stable(pixClkOut) && $stable(lineValidOut) && $stable(compositeHsyncOut))
    else $error("sync not held"); // R2
  mode_reset_a: assert property (@(posedge clk) disable iff (srst)
    wrEn && modeChgD && modeRstQ[`SCX_BIT_MODE_RST] && !modeRstD[`SCX_BIT_MODE_RST] == 1'b0
    |=> ##1 pixQ == 12'h000 && lineQ == 17'h00000) else $error("timing not restarted"); // R3
  mode_keep_a: assert property (@(posedge clk) disable iff (srst)
    modeChgQ && !modeRstQ[`SCX_BIT_MODE_RST] && !run |=> $stable(pixQ) && $stable(lineQ))
    else $error("timing reset while disabled"); // R3
  exp_join_a: assert property (@(posedge clk) disable iff (srst)
    expCount[10:3] == expMidQ && expCount[16:11] == expHighQ[5:0]
    && expCount[2:0] == expLowQ[2:0]) else $error("exposure count misassembled"); // R4
  exp_cap_a: assert property (@(posedge clk) disable iff (srst)
    expApplied <= `SCX_FRAME_LINES
    && (expCount <= `SCX_FRAME_LINES || expApplied == `SCX_FRAME_LINES))
    else $error("exposure not capped"); // R6
  unmapped_err_a: assert property (@(posedge clk) disable iff (srst)
    apbQ == scx_pkg::SCX_APB_WAIT && !mapped |=> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule

/* pkg/scx_clk_if.sv */
// divider control and tick between control and divider
`timescale 1ns/10ps
interface scx_clk_if;
  logic       divOn;
  logic [5:0] divField;
  logic       tick;
  modport ctrl (output divOn, output divField, input tick);
  modport div (input divOn, input divField, output tick);
endinterface

/* pkg/scx_pkg.sv */
// types shared by the sensor control slice
package scx_pkg;
  typedef enum logic [1:0] {
    SCX_APB_IDLE = 2'b00,
    SCX_APB_WAIT = 2'b01,
    SCX_APB_DONE = 2'b10
  } scx_apb_e;
  typedef logic [16:0] scx_exp_t;
endpackage

/* pkg/scx_regs.svh */
// register indices, field positions, reset values and timing counts
`ifndef SCX_REGS_SVH
`define SCX_REGS_SVH

// register indices, byte address is four times the index
`define SCX_IDX_PD_PIN    10'h00d
`define SCX_IDX_RSVD      10'h00e
`define SCX_IDX_MODE_RST  10'h00f
`define SCX_IDX_EXP_MID   10'h010
`define SCX_IDX_CLK_RATE  10'h011
`define SCX_IDX_RES_SEL   10'h012
`define SCX_IDX_EXP_HIGH  10'h045
`define SCX_IDX_EXP_LOW   10'h004
`define SCX_IDX_STATUS    10'h020

// reset values
`define SCX_RST_PD_PIN    8'h06
`define SCX_RST_RSVD      8'h01
`define SCX_RST_MODE_RST  8'h43
`define SCX_RST_EXP_MID   8'h63
`define SCX_RST_CLK_RATE  8'h00
`define SCX_RST_RES_SEL   8'h00
`define SCX_RST_EXP_HIGH  8'h00
`define SCX_RST_EXP_LOW   8'h00

// field positions
`define SCX_BIT_DATA_HOLD 2
`define SCX_BIT_SYNC_HOLD 1
`define SCX_BIT_MODE_RST  1
`define SCX_BIT_DIV_ON    6
`define SCX_RES_HI        6
`define SCX_RES_LO        3

// divider multiplier for a nonzero field
`define SCX_DIV_MULT      9'h002

// timing counts in divider ticks and lines
`define SCX_LINE_TICKS    12'h040
`define SCX_ACTIVE_PIX    12'h030
`define SCX_FRAME_LINES   17'h00028
`define SCX_ACTIVE_LINES  17'h00020
`define SCX_VSYNC_LINES   17'h00002

`endif
